// ---- include/hprw_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef HPRW_REGS_SVH
`define HPRW_REGS_SVH
`define HPRW_CLK_HZ 250000000
`define HPRW_TICK_HZ 32
`define HPRW_TICK_DIV (`HPRW_CLK_HZ / `HPRW_TICK_HZ)
`define HPRW_HOLD_LONG_S 4
`define HPRW_HOLD_LONG_TICKS (`HPRW_HOLD_LONG_S * `HPRW_TICK_HZ)
`define HPRW_HOLD_SHORT_TICKS (`HPRW_TICK_HZ / 4)
`define HPRW_RESET_PULSE_TICKS `HPRW_TICK_HZ
`define HPRW_EXTRA_S 5
`define HPRW_EXTRA_TICKS (`HPRW_EXTRA_S * `HPRW_TICK_HZ)
`define HPRW_REG_CFG 8'h00
`define HPRW_REG_WDOG 8'h04
`define HPRW_REG_STAT 8'h08
`define HPRW_REG_REPORT 8'h0c
`define HPRW_REG_DISP 8'h10
`define HPRW_REG_CTRL 8'h14
`define HPRW_BIT_AUTO 0
`define HPRW_BIT_RSTINV 1
`define HPRW_BIT_PWRINV 2
`define HPRW_BIT_WDACT 3
`define HPRW_BIT_BLANK 4
`define HPRW_BIT_KRESET 5
`define HPRW_BIT_KPWRON 6
`define HPRW_BIT_KPWROFF 7
`define HPRW_CFG_RESET 32'h0001_0120
`define HPRW_PULSE_DEFAULT 8'h20
`define HPRW_SENSE_DEFAULT 8'h01
`endif

// ---- include/hprw_pkg.sv ----
// Types for the host power and reset supervisor
package hprw_pkg;
  typedef enum logic [4:0] {
    HPRW_IDLE = 5'b00001,
    HPRW_RSTP = 5'b00010,
    HPRW_PWRP = 5'b00100,
    HPRW_REBOOT = 5'b01000,
    HPRW_LOCK = 5'b10000
  } hprw_state_t;
endpackage : hprw_pkg

// ---- hw/hprw_host_power_reset_watchdog.sv ----
// Host power and reset supervisor with watchdog and AXI4-Lite registers
`timescale 1ns/1ps
`include "hprw_regs.svh"
module hprw_host_power_reset_watchdog import hprw_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic confirmKey,
  input wire logic cancelKey,
  input wire logic supplyHeaderSense,
  input wire logic gpioSense,
  input wire logic resetLineIn,
  input wire logic powerLineIn,
  output logic resetLineOut,
  output logic resetLineOe,
  output logic powerLineOut,
  output logic powerLineOe,
  output logic displayBlank,
  output logic backlightOff,
  output logic showResetMsg,
  output logic showPowerMsg,
  output logic deviceReboot
);
  localparam int TICK_DIV = `HPRW_TICK_DIV;

  // Synchronisers for pins
  logic [6:0] pinMeta_q;
  logic [6:0] pinSync_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinMeta_q <= 7'h00;
      pinSync_q <= 7'h00;
    end else begin
      pinMeta_q <= {powerLineIn, resetLineIn, gpioSense, supplyHeaderSense, cancelKey,
                    confirmKey, 1'b0};
      pinSync_q <= pinMeta_q;
    end
  end

  // 32 Hz sample tick
  logic [22:0] divCnt_q;
  logic tick;
  assign tick = (divCnt_q == 23'(TICK_DIV - 1));
  always_ff @(posedge clock) begin
    if (!resetn) begin
      divCnt_q <= 23'h000000;
    end else if (tick) begin
      divCnt_q <= 23'h000000;
    end else begin
      divCnt_q <= divCnt_q + 23'h000001;
    end
  end

  // Registers
  logic [7:0] funcMask_q;
  logic [7:0] pulseLen_q;
  logic [7:0] senseSel_q;
  logic [7:0] wdTimeout_q;
  logic [31:0] reportMask_q;
  logic [31:0] dispCfg_q;
  logic [15:0] keyMask_q;
  logic wdLoad;
  logic [7:0] wdValue;
  logic cmdLock;
  hprw_state_t state_q;
  assign cmdLock = (state_q == HPRW_LOCK) || (state_q == HPRW_REBOOT);

  // Sampled pins at 32 Hz
  logic confirmDb_q;
  logic cancelDb_q;
  logic senseRaw_q;
  logic senseDb_q;
  logic senseDbPrev_q;
  logic rstPolHigh_q;
  logic pwrPolHigh_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      confirmDb_q <= 1'b0;
      cancelDb_q <= 1'b0;
      senseRaw_q <= 1'b0;
      senseDb_q <= 1'b0;
      senseDbPrev_q <= 1'b0;
    end else if (tick) begin
      confirmDb_q <= pinSync_q[1];
      cancelDb_q <= pinSync_q[2];
      senseRaw_q <= (senseSel_q == 8'h00) ? pinSync_q[4] : pinSync_q[3];
      senseDb_q <= senseRaw_q;
      senseDbPrev_q <= senseDb_q;
    end
  end

  // Auto polarity: line resting high means active low pull
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rstPolHigh_q <= 1'b0;
      pwrPolHigh_q <= 1'b0;
    end else if (tick && state_q == HPRW_IDLE) begin
      rstPolHigh_q <= !pinSync_q[5];
      pwrPolHigh_q <= !pinSync_q[6];
    end
  end

  // Key hold counters in ticks
  logic [7:0] confHold_q;
  logic [7:0] cancHold_q;
  logic confUsed_q;
  logic cancUsed_q;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      confHold_q <= 8'h00;
      cancHold_q <= 8'h00;
    end else if (tick) begin
      confHold_q <= !confirmDb_q ? 8'h00 : (confHold_q == 8'hff ? 8'hff : confHold_q + 8'h01);
      cancHold_q <= !cancelDb_q ? 8'h00 : (cancHold_q == 8'hff ? 8'hff : cancHold_q + 8'h01);
    end
  end

  // Watchdog seconds counter
  logic [7:0] wdCount_q;
  logic [4:0] secDiv_q;
  logic wdExpire;
  assign wdExpire = tick && secDiv_q == 5'h1f && wdCount_q == 8'h01;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wdCount_q <= 8'h00;
      secDiv_q <= 5'h00;
    end else if (wdLoad) begin
      wdCount_q <= wdValue;
      secDiv_q <= 5'h00;
    end else if (tick && wdCount_q != 8'h00) begin
      secDiv_q <= secDiv_q + 5'h01;
      if (secDiv_q == 5'h1f) wdCount_q <= wdCount_q - 8'h01;
    end
  end
  // Pulse sequencer
  logic [8:0] pulseCnt_q;
  logic [7:0] extraCnt_q;
  logic pwrOff_q;
  logic goReset;
  logic goPwrOn;
  logic goPwrOff;
  assign goReset = (funcMask_q[`HPRW_BIT_KRESET] && senseDb_q && !confUsed_q &&
                    confHold_q == 8'(`HPRW_HOLD_LONG_TICKS)) || wdExpire;
  assign goPwrOn = funcMask_q[`HPRW_BIT_KPWRON] && !senseDb_q && !confUsed_q &&
                   confHold_q == 8'(`HPRW_HOLD_SHORT_TICKS);
  assign goPwrOff = funcMask_q[`HPRW_BIT_KPWROFF] && senseDb_q && !cancUsed_q &&
                    cancHold_q == 8'(`HPRW_HOLD_LONG_TICKS);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= HPRW_IDLE;
      pulseCnt_q <= 9'h000;
      extraCnt_q <= 8'h00;
      pwrOff_q <= 1'b0;
      confUsed_q <= 1'b0;
      cancUsed_q <= 1'b0;
    end else begin
      if (tick && !confirmDb_q) confUsed_q <= 1'b0;
      if (tick && !cancelDb_q) cancUsed_q <= 1'b0;
      case (state_q)
        HPRW_IDLE: begin
          if (tick && goReset) begin
            state_q <= HPRW_RSTP;
            pulseCnt_q <= 9'(`HPRW_RESET_PULSE_TICKS);
            confUsed_q <= 1'b1;
          end else if (tick && goPwrOn) begin
            state_q <= HPRW_PWRP;
            pulseCnt_q <= {1'b0, pulseLen_q};
            pwrOff_q <= 1'b0;
            confUsed_q <= 1'b1;
          end else if (tick && goPwrOff) begin
            state_q <= HPRW_PWRP;
            pulseCnt_q <= {1'b0, pulseLen_q};
            extraCnt_q <= 8'(`HPRW_EXTRA_TICKS);
            pwrOff_q <= 1'b1;
            cancUsed_q <= 1'b1;
          end else if (tick && senseDb_q && !senseDbPrev_q) state_q <= HPRW_REBOOT;
        end
        HPRW_RSTP: begin
          if (tick) begin
            pulseCnt_q <= pulseCnt_q - 9'h001;
            if (pulseCnt_q == 9'h001) state_q <= HPRW_LOCK;
          end
        end
        HPRW_PWRP: begin
          if (tick) begin
            if (pulseCnt_q > 9'h001) begin
              pulseCnt_q <= pulseCnt_q - 9'h001;
            end else if (pwrOff_q && cancelDb_q && extraCnt_q != 8'h00) begin
              extraCnt_q <= extraCnt_q - 8'h01;
            end else begin
              pulseCnt_q <= 9'h000;
              state_q <= pwrOff_q ? HPRW_IDLE : HPRW_REBOOT;
            end
          end
        end
        HPRW_LOCK: begin
          if (tick) state_q <= HPRW_REBOOT;
        end
        HPRW_REBOOT: begin
          state_q <= HPRW_IDLE;
        end
        default: begin
          state_q <= HPRW_IDLE;
        end
      endcase
    end
  end
  // Line drive
  logic rstActiveHigh;
  logic pwrActiveHigh;
  assign rstActiveHigh = funcMask_q[`HPRW_BIT_AUTO] ? rstPolHigh_q : funcMask_q[`HPRW_BIT_RSTINV];
  assign pwrActiveHigh = funcMask_q[`HPRW_BIT_AUTO] ? pwrPolHigh_q : funcMask_q[`HPRW_BIT_PWRINV];
  always_ff @(posedge clock) begin
    if (!resetn) begin
      resetLineOe <= 1'b0;
      resetLineOut <= 1'b0;
      powerLineOe <= 1'b0;
      powerLineOut <= 1'b0;
      showResetMsg <= 1'b0;
      showPowerMsg <= 1'b0;
      deviceReboot <= 1'b0;
      displayBlank <= 1'b0;
      backlightOff <= 1'b0;
    end else begin
      resetLineOe <= (state_q == HPRW_RSTP);
      resetLineOut <= rstActiveHigh;
      powerLineOe <= (state_q == HPRW_PWRP);
      powerLineOut <= pwrActiveHigh;
      showResetMsg <= (state_q == HPRW_RSTP);
      showPowerMsg <= (state_q == HPRW_PWRP);
      deviceReboot <= (state_q == HPRW_REBOOT);
      displayBlank <= funcMask_q[`HPRW_BIT_BLANK] && !senseDb_q;
      backlightOff <= funcMask_q[`HPRW_BIT_BLANK] && !senseDb_q;
    end
  end
  // AXI4-Lite write channel
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_q[7:2] <= 6'h05 && awAddr_q != `HPRW_REG_STAT) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Register writes; byte lanes map to the optional configuration bytes
  logic cfgWrite;
  assign cfgWrite = doWrite && awAddr_q == `HPRW_REG_CFG && !cmdLock;
  assign wdLoad = doWrite && awAddr_q == `HPRW_REG_WDOG && wStrb_q[0] && !cmdLock;
  assign wdValue = wData_q[7:0];
  always_ff @(posedge clock) begin
    if (!resetn) begin
      funcMask_q <= 8'(`HPRW_CFG_RESET);
      pulseLen_q <= `HPRW_PULSE_DEFAULT;
      senseSel_q <= `HPRW_SENSE_DEFAULT;
      wdTimeout_q <= 8'h00;
      reportMask_q <= 32'h00000000;
      dispCfg_q <= 32'h00000000;
      keyMask_q <= 16'h0000;
    end else begin
      if (cfgWrite && wStrb_q[0]) funcMask_q <= wData_q[7:0] & 8'hf7;
      if (cfgWrite && wStrb_q[1] && wData_q[15:8] != 8'h00) begin
        pulseLen_q <= wData_q[15:8];
      end
      if (cfgWrite && wStrb_q[2]) senseSel_q <= {7'h00, wData_q[16]};
      if (wdLoad) wdTimeout_q <= wdValue;
      if (doWrite && awAddr_q == `HPRW_REG_REPORT && !cmdLock) reportMask_q <= wData_q;
      if (doWrite && awAddr_q == `HPRW_REG_DISP && !cmdLock) dispCfg_q <= wData_q;
      if (doWrite && awAddr_q == `HPRW_REG_CTRL && !cmdLock) keyMask_q <= wData_q[15:0];
    end
  end
  // AXI4-Lite read channel
  logic [31:0] readMux;
  always_comb begin
    case (s_axi_araddr)
      `HPRW_REG_CFG: readMux = {8'h00, senseSel_q, pulseLen_q, funcMask_q};
      `HPRW_REG_WDOG: readMux = {24'h000000, wdTimeout_q};
      `HPRW_REG_STAT: readMux = {8'h00, senseSel_q, wdCount_q,
                                 funcMask_q | {4'h0, wdCount_q != 8'h00, 3'h0}};
      `HPRW_REG_REPORT: readMux = reportMask_q;
      `HPRW_REG_DISP: readMux = dispCfg_q;
      `HPRW_REG_CTRL: readMux = {16'h0000, keyMask_q};
      default: readMux = 32'h00000000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readMux;
      s_axi_rresp <= (s_axi_araddr[7:2] <= 6'h05 && s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : hprw_host_power_reset_watchdog

// ---- tb/hprw_checker.sv ----
// Port-level assertions for the host power and reset supervisor
`timescale 1ns/1ps
module hprw_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic resetLineOe,
  input wire logic powerLineOe,
  input wire logic showResetMsg,
  input wire logic showPowerMsg,
  input wire logic displayBlank,
  input wire logic backlightOff,
  input wire logic deviceReboot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_reset_quiet: assert property (
    $rose(resetn) |-> !resetLineOe && !powerLineOe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_lines_apart: assert property (!(resetLineOe && powerLineOe))
    else $error("both lines driven");
  a_reset_msg: assert property (resetLineOe |-> showResetMsg)
    else $error("reset pulse without message");
  a_power_msg: assert property (powerLineOe |-> showPowerMsg)
    else $error("power pulse without message");
  a_blank_pair: assert property (displayBlank == backlightOff)
    else $error("blank and backlight disagree");
  a_reboot_once: assert property (deviceReboot |=> !deviceReboot)
    else $error("reboot pulse too long");
endmodule : hprw_checker
bind hprw_host_power_reset_watchdog hprw_checker chk (.clock(clock), .resetn(resetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .resetLineOe(resetLineOe),
  .powerLineOe(powerLineOe), .showResetMsg(showResetMsg), .showPowerMsg(showPowerMsg),
  .displayBlank(displayBlank), .backlightOff(backlightOff), .deviceReboot(deviceReboot));

// ---- tb/hprw_atx_host_model.sv ----
// Host motherboard side: pulled-up power and reset inputs and host-alive sense
`timescale 1ns/1ps
module hprw_atx_host_model (
  input wire logic resetLineOut,
  input wire logic resetLineOe,
  input wire logic powerLineOut,
  input wire logic powerLineOe,
  input wire logic hostOn,
  output logic resetLineIn,
  output logic powerLineIn,
  output logic supplyHeaderSense,
  output logic gpioSense
);
  // Released lines rest at the board pull-up, pins left high-impedance
  assign resetLineIn = resetLineOe ? resetLineOut : 1'b1;
  assign powerLineIn = powerLineOe ? powerLineOut : 1'b1;
  // Pin 1 resistive pull-up follows the host supply
  assign gpioSense = hostOn;
  assign supplyHeaderSense = hostOn;
endmodule : hprw_atx_host_model

// ---- tb/hprw_host_power_reset_watchdog_tb.sv ----
// Self-checking bench for the host power and reset supervisor
`timescale 1ns/1ps
`include "hprw_regs.svh"
module hprw_host_power_reset_watchdog_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic confirmKey = 1'b0, cancelKey = 1'b0, hostOn = 1'b0;
  logic supplyHeaderSense, gpioSense, resetLineIn, powerLineIn;
  logic resetLineOut, resetLineOe, powerLineOut, powerLineOe;
  logic displayBlank, backlightOff, showResetMsg, showPowerMsg, deviceReboot;
  // Line drive, messages, reboot and pad levels seen by the host
  wire [8:0] lineState = {resetLineOe, powerLineOe, showResetMsg, showPowerMsg, deviceReboot,
    resetLineOut, powerLineOut, resetLineIn, powerLineIn};
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  localparam logic [31:0] CFG_RST = `HPRW_CFG_RESET;
  localparam logic [31:0] CFG_DEF = {8'h00, `HPRW_SENSE_DEFAULT, `HPRW_PULSE_DEFAULT,
    CFG_RST[7:4], 1'b0, CFG_RST[2:0]};
  localparam logic [31:0] STAT_DEF = {8'h00, CFG_DEF[23:16], 8'h00, CFG_DEF[7:0]};
  logic [31:0] cfgData [6] = '{32'h0000_00ef, 32'h0000_ffe7, 32'h0000_0000, 32'h0000_0100,
    32'h0000_0000, 32'h0001_2010};
  logic [3:0] cfgStrb [6] = '{4'h1, 4'h3, 4'h2, 4'h2, 4'h4, 4'h7};
  logic [31:0] cfgExp [6] = '{32'h0001_20e7, 32'h0001_ffe7, 32'h0001_ffe7, 32'h0001_01e7,
    32'h0000_01e7, 32'h0001_2010};
  hprw_host_power_reset_watchdog uut (.clock(clock), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .confirmKey(confirmKey),
    .cancelKey(cancelKey), .supplyHeaderSense(supplyHeaderSense), .gpioSense(gpioSense),
    .resetLineIn(resetLineIn), .powerLineIn(powerLineIn), .resetLineOut(resetLineOut),
    .resetLineOe(resetLineOe), .powerLineOut(powerLineOut), .powerLineOe(powerLineOe),
    .displayBlank(displayBlank), .backlightOff(backlightOff), .showResetMsg(showResetMsg),
    .showPowerMsg(showPowerMsg), .deviceReboot(deviceReboot));
  hprw_atx_host_model host (.resetLineOut(resetLineOut), .resetLineOe(resetLineOe),
    .powerLineOut(powerLineOut), .powerLineOe(powerLineOe), .hostOn(hostOn),
    .resetLineIn(resetLineIn), .powerLineIn(powerLineIn),
    .supplyHeaderSense(supplyHeaderSense), .gpioSense(gpioSense));
  always #2 clock = ~clock;
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic doReset();
    resetn <= 1'b0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
  endtask : doReset
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axiRead
  // Read a register and compare both data and an OKAY response
  task automatic readCheck(input string name, input logic [7:0] a, input logic [31:0] exp);
    axiRead(a, rd, rs);
    check(name, {30'h0, rs}, 32'h0);
    check(name, rd, exp);
  endtask : readCheck
  task automatic writeCheck(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] exp);
    axiWrite(a, d, s, rs);
    check("bresp", {30'h0, rs}, {30'h0, exp});
  endtask : writeCheck
  initial begin
    doReset();
    @(posedge clock);
    check("lines idle", {23'h0, lineState}, 32'h0000_0003);
    readCheck("cfg default", `HPRW_REG_CFG, CFG_DEF);
    readCheck("stat default", `HPRW_REG_STAT, STAT_DEF);
    for (int i = 0; i < 6; i++) begin
      writeCheck(`HPRW_REG_CFG, cfgData[i], cfgStrb[i], 2'b00);
      readCheck("cfg bytes", `HPRW_REG_CFG, cfgExp[i]);
    end
    repeat (4) @(posedge clock);
    check("blank while host off", {30'h0, displayBlank, backlightOff}, 32'h3);
    writeCheck(`HPRW_REG_WDOG, 32'h0000_0005, 4'hf, 2'b00);
    readCheck("stat wd 5", `HPRW_REG_STAT, 32'h0001_0518);
    writeCheck(`HPRW_REG_WDOG, 32'h0000_00ff, 4'hf, 2'b00);
    readCheck("stat wd 255", `HPRW_REG_STAT, 32'h0001_ff18);
    writeCheck(`HPRW_REG_STAT, 32'h0000_0000, 4'hf, 2'b10);
    readCheck("stat kept", `HPRW_REG_STAT, 32'h0001_ff18);
    writeCheck(`HPRW_REG_WDOG, 32'h0000_0000, 4'hf, 2'b00);
    readCheck("stat wd off", `HPRW_REG_STAT, 32'h0001_0010);
    writeCheck(`HPRW_REG_REPORT, 32'h5a5a_a5a5, 4'hf, 2'b00);
    readCheck("report", `HPRW_REG_REPORT, 32'h5a5a_a5a5);
    writeCheck(`HPRW_REG_DISP, 32'ha5a5_5a5a, 4'hf, 2'b00);
    readCheck("display", `HPRW_REG_DISP, 32'ha5a5_5a5a);
    writeCheck(`HPRW_REG_CTRL, 32'h5a5a_a5a5, 4'hf, 2'b00);
    readCheck("key masks", `HPRW_REG_CTRL, 32'h0000_a5a5);
    writeCheck(`HPRW_REG_CFG, 32'h0000_0016, 4'h1, 2'b00);
    readCheck("cfg invert", `HPRW_REG_CFG, 32'h0001_2016);
    repeat (2) @(posedge clock);
    check("lines inverted", {23'h0, lineState}, 32'h0000_000f);
    writeCheck(8'h18, 32'h0000_0000, 4'hf, 2'b10);
    axiRead(8'h18, rd, rs);
    check("unmapped read", {rs, rd[29:0]}, 32'h8000_0000);
    check("unmapped data", rd, 32'h0000_0000);
    writeCheck(`HPRW_REG_WDOG, 32'h0000_0009, 4'hf, 2'b00);
    doReset();
    readCheck("cfg after reset", `HPRW_REG_CFG, CFG_DEF);
    readCheck("stat after reset", `HPRW_REG_STAT, STAT_DEF);
    results();
  end
endmodule : hprw_host_power_reset_watchdog_tb
